// *** src/adc_front_end_defines.vh ***
// constants and timing codes for the converter front end pin logic
//
// What this block does
// - idle ready pin drives high when idle-high select is 1, else floats
// - each completed conversion gives one low pulse on the ready pin
// - ready pulse timed from master clock, fixed width per clock setup
// - ready pulse never held; timing set only by clock, ratio, divider
// - pulse lasts half a sample clock period, repeats at output rate
// - ready pulse generation ignores serial port activity completely
// - external clock select disables oscillator, uses clock input pin
// - analog-side clock is master clock divided by chosen divider
// - external reference select disables internal reference, else switch it on
// - serial port ignores everything while chip select is high
// - chip select fall starts a transaction, rise ends it
// - no serial communication while hard reset pin is low
// - serial input bits sampled on rising serial clock edges
// - serial output bits shifted on falling serial clock edges
// - works in clock modes 0,0 and 1,1
// - serial clock and master clock treated as unrelated domains
// - output released while the command byte is received
// - output released in writes, chip select high, or hard reset
// - output driven only during read data phase
// - half duplex: never input and output in the same bit periods
// - every transaction opens with an 8-bit read or write command
// - divider codes 0 to 3 divide by 1, 2, 4, 8; default 1
// - sample clock is analog-side clock divided by four
// - output rate clock is sample clock divided by oversampling ratio
`ifndef ADC_FRONT_END_DEFINES_VH
`define ADC_FRONT_END_DEFINES_VH

// synchroniser lanes
`define PIN_N          5
`define PIN_CS         0
`define PIN_SCK        1
`define PIN_SDI        2
`define PIN_RST        3
`define PIN_CLKIN      4
// cs high, reset pin low, rest low
`define PIN_RST_VAL    5'h01

// command byte
`define CMD_W          8
`define CMD_CNT_W      3
`define CMD_LAST       3'h7
`define CMD_READ_BIT   0

// serial phases
`define PH_IDLE        2'h0
`define PH_CMD         2'h1
`define PH_WRITE       2'h2
`define PH_READ        2'h3

// clock dividers
`define PRE_ONE        3'h1
`define AM_PH_LAST     2'h3
`define AM_PH_HALF     2'h2
`define OSR_MIN        13'h0020
`define OSR_CNT_ZERO   13'h0000
`define OSR_ONE        13'h0001

`endif

// *** src/two_entry_buffer.v ***
// two-entry buffer with valid and ready on both sides
`timescale 1ns/100ps
module two_entry_buffer #(
   parameter W = 24
) (
   // clock and reset
   input  wire         clk_i,
   input  wire         rst_i,
   // filling side
   input  wire [W-1:0] in_data_i,
   input  wire         in_valid_i,
   output wire         in_ready_o,
   // draining side
   output wire [W-1:0] out_data_o,
   output wire         out_valid_o,
   input  wire         out_ready_i
);

   reg [W-1:0] data0_reg;
   reg [W-1:0] data1_reg;
   reg [1:0]   cnt_reg;
   reg [1:0]   cnt_next;
   reg         full_reg;
   reg         valid_reg;
   wire        push;
   wire        pop;

   assign push        = in_valid_i & ~full_reg;
   assign pop         = out_ready_i & valid_reg;
   assign in_ready_o  = ~full_reg;
   assign out_valid_o = valid_reg;
   assign out_data_o  = data0_reg;

   always @* begin
      cnt_next = cnt_reg;
      if (push & ~pop) begin
         cnt_next = cnt_reg + 2'h1;
      end else if (pop & ~push) begin
         cnt_next = cnt_reg - 2'h1;
      end
   end

   always @(posedge clk_i) begin
      if (rst_i) begin
         data0_reg <= {W{1'b0}};
         data1_reg <= {W{1'b0}};
         cnt_reg   <= 2'h0;
         full_reg  <= 1'b0;
         valid_reg <= 1'b0;
      end else begin
         cnt_reg   <= cnt_next;
         full_reg  <= (cnt_next == 2'h2);
         valid_reg <= (cnt_next != 2'h0);
         if (pop) begin
            data0_reg <= (push && cnt_reg == 2'h1) ? in_data_i : data1_reg;
         end
         if (push) begin
            if (cnt_reg == 2'h0) begin
               data0_reg <= in_data_i;
            end else if (cnt_reg == 2'h1 && !pop) begin
               data1_reg <= in_data_i;
            end else if (cnt_reg == 2'h2 || (cnt_reg == 2'h1 && pop)) begin
               data1_reg <= in_data_i;
            end
         end
      end
   end

endmodule

// *** src/adc_front_end_pins.v ***
// pin-level serial port, ready pulse and clock/reference select logic
`timescale 1ns/100ps
`include "adc_front_end_defines.vh"
module adc_front_end_pins #(
   parameter DATA_W = 24
) (
   // clock and reset
   input  wire              core_clk_i,
   input  wire              srst_i,
   // serial pins
   input  wire              chip_select_n_i,
   input  wire              sck_i,
   input  wire              sdi_i,
   output reg               sdo_o,
   output reg               sdo_oe_o,
   input  wire              hard_reset_n_i,
   // conversion-ready pin
   output reg               conversion_ready_pin_o,
   output reg               conversion_ready_pin_oe_o,
   // clock source
   input  wire              clock_input_pin_i,
   input  wire              osc_tick_i,
   output reg               osc_enable_o,
   // reference source
   output reg               int_ref_enable_o,
   output reg               ref_switch_o,
   // configuration bits
   input  wire              ready_pin_idle_high_select_i,
   input  wire              external_clock_select_i,
   input  wire              external_reference_select_i,
   input  wire [1:0]        analog_clock_divider_i,
   input  wire [2:0]        oversampling_ratio_i,
   // conversion results
   input  wire [DATA_W-1:0] result_data_i,
   input  wire              result_valid_i,
   output wire              result_ready_o,
   // decoded serial traffic and conversion done pulse
   output reg  [`CMD_W-1:0] cmd_o,
   output reg               cmd_valid_o,
   output reg               cmd_read_o,
   output reg  [`CMD_W-1:0] wr_data_o,
   output reg               wr_valid_o,
   output reg               busy_o,
   output reg               conv_done_o
);

   // pin synchronisers: third and second flop must agree
   reg [`PIN_N-1:0] sync1_reg;
   reg [`PIN_N-1:0] sync2_reg;
   reg [`PIN_N-1:0] sync3_reg;
   reg [`PIN_N-1:0] pin_reg;
   reg [`PIN_N-1:0] pin_prev_reg;
   wire [`PIN_N-1:0] pin_raw;
   wire [`PIN_N-1:0] pin_rst = `PIN_RST_VAL;

   assign pin_raw = {clock_input_pin_i, hard_reset_n_i, sdi_i, sck_i, chip_select_n_i};

   genvar gi;
   generate
      for (gi = 0; gi < `PIN_N; gi = gi + 1) begin : g_sync
         always @(posedge core_clk_i) begin
            if (srst_i) begin
               sync1_reg[gi]    <= pin_rst[gi];
               sync2_reg[gi]    <= pin_rst[gi];
               sync3_reg[gi]    <= pin_rst[gi];
               pin_reg[gi]      <= pin_rst[gi];
               pin_prev_reg[gi] <= pin_rst[gi];
            end else begin
               sync1_reg[gi]    <= pin_raw[gi];
               sync2_reg[gi]    <= sync1_reg[gi];
               sync3_reg[gi]    <= sync2_reg[gi];
               if (sync2_reg[gi] == sync3_reg[gi]) begin
                  pin_reg[gi] <= sync3_reg[gi];
               end
               pin_prev_reg[gi] <= pin_reg[gi];
            end
         end
      end
   endgenerate

   wire cs_n     = pin_reg[`PIN_CS];
   wire sdi      = pin_reg[`PIN_SDI];
   wire sck_rise = pin_reg[`PIN_SCK] & ~pin_prev_reg[`PIN_SCK];
   wire sck_fall = ~pin_reg[`PIN_SCK] & pin_prev_reg[`PIN_SCK];
   wire cs_fall  = ~cs_n & pin_prev_reg[`PIN_CS];
   wire clkin_rise = pin_reg[`PIN_CLKIN] & ~pin_prev_reg[`PIN_CLKIN];

   // hard reset pin resets all but the pin synchronisers
   wire rst = srst_i | ~pin_reg[`PIN_RST];

   wire mclk_tick = external_clock_select_i ? clkin_rise : osc_tick_i;

   // ---------------- ready pulse timing ----------------
   reg [2:0]  pre_cnt_reg;
   reg [1:0]  am_ph_reg;
   reg [12:0] osr_cnt_reg;
   reg        pulse_reg;
   wire [2:0]  pre_last = (`PRE_ONE << analog_clock_divider_i) - `PRE_ONE;
   wire [12:0] osr_last = (`OSR_MIN << oversampling_ratio_i) - `OSR_ONE;
   wire        am_tick  = mclk_tick && (pre_cnt_reg >= pre_last);
   wire        dm_tick  = am_tick && (am_ph_reg == `AM_PH_LAST);
   wire        dr_tick  = dm_tick && (osr_cnt_reg >= osr_last);

   always @(posedge core_clk_i) begin
      if (rst) begin
         pre_cnt_reg <= 3'h0;
         am_ph_reg   <= 2'h0;
         osr_cnt_reg <= `OSR_CNT_ZERO;
         pulse_reg   <= 1'b0;
         conv_done_o <= 1'b0;
      end else begin
         conv_done_o <= dr_tick;
         if (mclk_tick) begin
            pre_cnt_reg <= am_tick ? 3'h0 : pre_cnt_reg + 3'h1;
         end
         if (am_tick) begin
            // sample clock is a quarter of the analog clock
            am_ph_reg <= am_ph_reg + 2'h1;
         end
         if (dm_tick) begin
            osr_cnt_reg <= dr_tick ? `OSR_CNT_ZERO : osr_cnt_reg + `OSR_ONE;
         end
         // pulse for half a sample period
         if (dr_tick) begin
            pulse_reg <= 1'b1;
         end else if (am_tick && am_ph_reg == `AM_PH_HALF - 2'h1) begin
            pulse_reg <= 1'b0;
         end
      end
   end

   // ready pin driven only from the divider chain and the idle-high select
   always @(posedge core_clk_i) begin
      if (rst) begin
         conversion_ready_pin_o    <= 1'b1;
         conversion_ready_pin_oe_o <= 1'b0;
         osc_enable_o              <= 1'b1;
         int_ref_enable_o          <= 1'b1;
         ref_switch_o              <= 1'b1;
      end else begin
         conversion_ready_pin_o    <= ~pulse_reg;
         conversion_ready_pin_oe_o <= pulse_reg | ready_pin_idle_high_select_i;
         osc_enable_o              <= ~external_clock_select_i;
         // internal reference on and switched to pin unless external reference selected
         int_ref_enable_o          <= ~external_reference_select_i;
         ref_switch_o              <= ~external_reference_select_i;
      end
   end

   // ---------------- serial port ----------------
   reg [1:0]            phase_reg;
   reg [`CMD_CNT_W-1:0] bit_cnt_reg;
   reg [`CMD_W-1:0]     in_sh_reg;
   reg [DATA_W-1:0]     out_sh_reg;
   reg [5:0]            out_cnt_reg;
   wire [DATA_W-1:0]    buf_data;
   wire                 buf_valid;
   wire                 word_start = (out_cnt_reg == 6'h00);
   wire                 buf_pop = (phase_reg == `PH_READ) && sck_fall && word_start && !cs_n;
   wire [`CMD_W-1:0]    in_next = {in_sh_reg[`CMD_W-2:0], sdi};
   wire [DATA_W-1:0]    word = buf_valid ? buf_data : {DATA_W{1'b0}};

   two_entry_buffer #(
      .W (DATA_W)
   ) u_result_buf (
      .clk_i       (core_clk_i),
      .rst_i       (rst),
      .in_data_i   (result_data_i),
      .in_valid_i  (result_valid_i),
      .in_ready_o  (result_ready_o),
      .out_data_o  (buf_data),
      .out_valid_o (buf_valid),
      .out_ready_i (buf_pop)
   );

   always @(posedge core_clk_i) begin
      if (rst) begin
         phase_reg   <= `PH_IDLE;
         bit_cnt_reg <= {`CMD_CNT_W{1'b0}};
         in_sh_reg   <= {`CMD_W{1'b0}};
         out_sh_reg  <= {DATA_W{1'b0}};
         out_cnt_reg <= 6'h00;
         sdo_o       <= 1'b0;
         sdo_oe_o    <= 1'b0;
         cmd_o       <= {`CMD_W{1'b0}};
         cmd_valid_o <= 1'b0;
         cmd_read_o  <= 1'b0;
         wr_data_o   <= {`CMD_W{1'b0}};
         wr_valid_o  <= 1'b0;
         busy_o      <= 1'b0;
      end else begin
         cmd_valid_o <= 1'b0;
         wr_valid_o  <= 1'b0;
         if (cs_n) begin
            // chip select high ends and ignores all
            phase_reg <= `PH_IDLE;
            sdo_oe_o  <= 1'b0;
            busy_o    <= 1'b0;
         end else if (cs_fall) begin
            // new transaction opens with a command byte
            phase_reg   <= `PH_CMD;
            bit_cnt_reg <= {`CMD_CNT_W{1'b0}};
            out_cnt_reg <= 6'h00;
            sdo_oe_o    <= 1'b0;
            busy_o      <= 1'b1;
         end else begin
            case (phase_reg)
               `PH_CMD: begin
                  if (sck_rise) begin
                     in_sh_reg   <= in_next;
                     bit_cnt_reg <= bit_cnt_reg + 1'b1;
                     if (bit_cnt_reg == `CMD_LAST) begin
                        cmd_o       <= in_next;
                        cmd_valid_o <= 1'b1;
                        cmd_read_o  <= in_next[`CMD_READ_BIT];
                        phase_reg   <= in_next[`CMD_READ_BIT] ? `PH_READ : `PH_WRITE;
                     end
                  end
               end
               `PH_WRITE: begin
                  if (sck_rise) begin
                     in_sh_reg   <= in_next;
                     bit_cnt_reg <= bit_cnt_reg + 1'b1;
                     if (bit_cnt_reg == `CMD_LAST) begin
                        wr_data_o  <= in_next;
                        wr_valid_o <= 1'b1;
                     end
                  end
               end
               `PH_READ: begin
                  // shift out on fall, input ignored
                  if (sck_fall) begin
                     sdo_oe_o <= 1'b1;
                     if (word_start) begin
                        sdo_o      <= word[DATA_W-1];
                        out_sh_reg <= {word[DATA_W-2:0], 1'b0};
                     end else begin
                        sdo_o      <= out_sh_reg[DATA_W-1];
                        out_sh_reg <= {out_sh_reg[DATA_W-2:0], 1'b0};
                     end
                     out_cnt_reg <= (out_cnt_reg == DATA_W - 1) ? 6'h00 : out_cnt_reg + 6'h01;
                  end
               end
               default: begin
                  phase_reg <= `PH_IDLE;
               end
            endcase
         end
      end
   end

endmodule

// *** verification/adc_pins_chk.sv ***
// assertions on the converter pin logic ports
`timescale 1ns/100ps
module adc_pins_chk (
   // clock and reset
   input logic core_clk_i,
   input logic srst_i,
   // serial port
   input logic chip_select_n_i,
   input logic hard_reset_n_i,
   input logic sdo_oe_o,
   input logic busy_o,
   input logic cmd_valid_o,
   input logic cmd_read_o,
   input logic wr_valid_o,
   // ready pin
   input logic conversion_ready_pin_o,
   input logic conversion_ready_pin_oe_o,
   input logic conv_done_o,
   // selects
   input logic ready_pin_idle_high_select_i,
   input logic external_clock_select_i,
   input logic external_reference_select_i,
   input logic osc_enable_o,
   input logic int_ref_enable_o,
   input logic ref_switch_o
);
   default clocking @(posedge core_clk_i); endclocking
   default disable iff (srst_i || !hard_reset_n_i);
   idle_level_a: assert property (($stable(ready_pin_idle_high_select_i) && hard_reset_n_i)[*8]
      ##0 conversion_ready_pin_o |-> conversion_ready_pin_oe_o == ready_pin_idle_high_select_i) else $error("idle drive");
   done_pin_a: assert property (conv_done_o |=> !conversion_ready_pin_o && conversion_ready_pin_oe_o)
      else $error("no low pulse");
   done_single_a: assert property (conv_done_o |=> !conv_done_o) else $error("done too long");
   pin_cause_a: assert property ($fell(conversion_ready_pin_o) |-> $past(conv_done_o))
      else $error("pulse without conversion");
   cs_quiet_a: assert property (chip_select_n_i[*8] |-> !sdo_oe_o && !busy_o) else $error("port active");
   hard_quiet_a: assert property (@(posedge core_clk_i) disable iff (srst_i)
      (!hard_reset_n_i)[*6] |-> !sdo_oe_o && !busy_o) else $error("port active in reset");
   read_only_a: assert property (sdo_oe_o |-> cmd_read_o && busy_o) else $error("output outside read");
   cmd_hiz_a: assert property (cmd_valid_o || wr_valid_o |-> !sdo_oe_o) else $error("output driven");
   osc_sel_a: assert property (($stable(external_clock_select_i) && hard_reset_n_i)[*8]
      |-> osc_enable_o == !external_clock_select_i) else $error("oscillator enable");
   ref_sel_a: assert property (($stable(external_reference_select_i) && hard_reset_n_i)[*8]
      |-> int_ref_enable_o == !external_reference_select_i && ref_switch_o == int_ref_enable_o) else $error("ref");
   cover property (conv_done_o);
   cover property (sdo_oe_o);
   cover property (wr_valid_o);
endmodule
bind adc_front_end_pins adc_pins_chk chk (.core_clk_i, .srst_i, .chip_select_n_i, .hard_reset_n_i, .sdo_oe_o, .busy_o,
   .cmd_valid_o, .cmd_read_o, .wr_valid_o, .conversion_ready_pin_o, .conversion_ready_pin_oe_o, .conv_done_o,
   .ready_pin_idle_high_select_i, .external_clock_select_i, .external_reference_select_i, .osc_enable_o,
   .int_ref_enable_o, .ref_switch_o);

// *** verification/host_spi_model.sv ***
// host serial master model driving the converter pins
`timescale 1ns/100ps
module host_spi_model (
   // clock
   input  wire core_clk_i,
   // serial pins
   input  wire sdo_o,
   input  wire sdo_oe_o,
   output reg  chip_select_n_o,
   output reg  sck_o,
   output reg  sdi_o
);
   localparam HALF = 8;
   initial begin
      chip_select_n_o = 1'b1;
      sck_o = 1'b0;
      sdi_o = 1'b0;
   end
   // mode set while deselected, select frames each command
   task automatic xfer(input bit cpol, input [7:0] cmd, input [7:0] wdat, input int nb, output [23:0] rx);
      int i;
      begin
         rx = 24'h000000;
         sck_o <= cpol;
         repeat (HALF) @(posedge core_clk_i);
         chip_select_n_o <= 1'b0;
         for (i = 0; i < 8 + nb; i++) begin
            repeat (HALF) @(posedge core_clk_i);
            sck_o <= 1'b0;
            // data line toggles once released in the read phase
            sdi_o <= (i < 8) ? cmd[7-i] : (cmd[0] ? ~sdi_o : wdat[15-i]);
            repeat (HALF) @(posedge core_clk_i);
            // rising edge after 80 ns of stable data
            sck_o <= 1'b1;
            if (i >= 8)
               rx = {rx[22:0], sdo_oe_o === 1'b1 && sdo_o === 1'b1};
         end
         repeat (HALF) @(posedge core_clk_i);
         sck_o <= cpol;
         repeat (HALF) @(posedge core_clk_i);
         chip_select_n_o <= 1'b1;
         repeat (HALF) @(posedge core_clk_i);
      end
   endtask
endmodule

// *** verification/adc_front_end_serial_and_ready_pins_bench.sv ***
// self-checking bench for the converter pin logic
`timescale 1ns/100ps
module adc_front_end_serial_and_ready_pins_bench;
   reg         core_clk_i = 1'b0, srst_i = 1'b1, hard_reset_n_i = 1'b1, osc_tick_i = 1'b1;
   reg         ready_pin_idle_high_select_i = 1'b0, external_clock_select_i = 1'b0;
   reg         external_reference_select_i = 1'b0, result_valid_i = 1'b0;
   reg  [1:0]  analog_clock_divider_i = 2'h0;
   reg  [2:0]  oversampling_ratio_i = 3'h0, ext_cnt = 3'h0;
   reg  [23:0] result_data_i = 24'h000000;
   reg  [7:0]  wr_last = 8'h00;
   wire        chip_select_n_i, sck_i, sdi_i, sdo_o, sdo_oe_o, conversion_ready_pin_o, conversion_ready_pin_oe_o;
   wire        osc_enable_o, int_ref_enable_o, ref_switch_o, result_ready_o, wr_valid_o, busy_o;
   wire [7:0]  cmd_o, wr_data_o;
   wire        clock_input_pin_i = ext_cnt[2];
   int         bad_count = 0, cmp_count = 0, cycles = 0, oe_cnt = 0, busy_cnt = 0;
   adc_front_end_pins uut (.core_clk_i, .srst_i, .chip_select_n_i, .sck_i, .sdi_i, .sdo_o, .sdo_oe_o, .hard_reset_n_i,
      .conversion_ready_pin_o, .conversion_ready_pin_oe_o, .clock_input_pin_i, .osc_tick_i, .osc_enable_o,
      .int_ref_enable_o, .ref_switch_o, .ready_pin_idle_high_select_i, .external_clock_select_i,
      .external_reference_select_i, .analog_clock_divider_i, .oversampling_ratio_i, .result_data_i,
      .result_valid_i, .result_ready_o, .cmd_o, .cmd_valid_o(), .cmd_read_o(), .wr_data_o, .wr_valid_o,
      .busy_o, .conv_done_o());
   host_spi_model host (.core_clk_i, .sdo_o, .sdo_oe_o, .chip_select_n_o(chip_select_n_i), .sck_o(sck_i),
      .sdi_o(sdi_i));
   always #5 core_clk_i = ~core_clk_i;
   always @(posedge core_clk_i) begin
      ext_cnt <= ext_cnt + 3'h1;
      cycles <= cycles + 1;
      if (sdo_oe_o === 1'b1) oe_cnt <= oe_cnt + 1;
      if (busy_o === 1'b1) busy_cnt <= busy_cnt + 1;
      if (wr_valid_o === 1'b1) wr_last <= wr_data_o;
      if (cycles == 60000) begin
         bad_count++;
         end_of_test;
      end
   end
   task end_of_test;
      begin
         $display("checks %0d mismatches %0d", cmp_count, bad_count);
         if (bad_count == 0 && cmp_count > 0)
            $display("Regression OK");
         else
            $display("Regression broken");
         $finish;
      end
   endtask
   task automatic check(input string name, input [31:0] seen, input [31:0] exp);
      begin
         cmp_count++;
         if (seen !== exp) begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
         end
      end
   endtask
   // one low pulse: width then distance to the next fall, in core cycles
   task automatic meas(output int lo, output int per);
      begin
         lo = 0;
         per = 0;
         while (conversion_ready_pin_o !== 1'b0 && per < 5000) begin
            @(posedge core_clk_i);
            per++;
         end
         per = 0;
         while (conversion_ready_pin_o === 1'b0) begin
            @(posedge core_clk_i);
            lo++;
         end
         per = lo;
         while (conversion_ready_pin_o !== 1'b0 && per < 5000) begin
            @(posedge core_clk_i);
            per++;
         end
      end
   endtask
   task automatic s_select;
      int i;
      begin
         for (i = 0; i < 4; i++) begin
            external_clock_select_i <= i[0];
            external_reference_select_i <= i[1];
            repeat (4) @(posedge core_clk_i);
            check("osc_enable", osc_enable_o, !i[0]);
            check("int_ref", int_ref_enable_o, !i[1]);
            check("ref_switch", ref_switch_o, !i[1]);
         end
         external_clock_select_i <= 1'b0;
      end
   endtask
   // pulses keep their timing while writes run on the serial port
   task automatic s_ready;
      int k, lo, per, oe0;
      reg [23:0] rx;
      begin
         for (k = 0; k < 5; k++) begin
            analog_clock_divider_i <= (k < 4) ? k[1:0] : 2'h0;
            oversampling_ratio_i <= (k < 4) ? 3'h0 : 3'h2;
            ready_pin_idle_high_select_i <= k[0];
            oe0 = oe_cnt;
            fork
               begin
                  meas(lo, per);
                  meas(lo, per);
               end
               host.xfer(k[0], 8'h40, 8'hA0 + k[7:0], 8, rx);
            join
            check("pulse width", lo, 32'd2 << analog_clock_divider_i);
            check("pulse period", per, (32'd128 << analog_clock_divider_i) << oversampling_ratio_i);
            check("write byte", wr_last, 8'hA0 + k[7:0]);
            check("write command", cmd_o, 8'h40);
            check("write oe", oe_cnt, oe0);
            repeat (20) @(posedge core_clk_i);
            while (conversion_ready_pin_o === 1'b0) @(posedge core_clk_i);
            check("idle oe", conversion_ready_pin_oe_o, k[0]);
            check("idle level", conversion_ready_pin_o, 1'b1);
         end
         external_clock_select_i <= 1'b1;
         osc_tick_i <= 1'b0;
         meas(lo, per);
         meas(lo, per);
         check("ext width", lo, 32'd16);
         check("ext period", per, 32'd4096);
         external_clock_select_i <= 1'b0;
         osc_tick_i <= 1'b1;
      end
   endtask
   task automatic s_read;
      reg [23:0] rx;
      begin
         result_data_i <= 24'h9A5C3E;
         result_valid_i <= 1'b1;
         @(posedge core_clk_i);
         result_data_i <= 24'h1234F0;
         @(posedge core_clk_i);
         result_data_i <= 24'hFFFFFF;
         repeat (2) @(posedge core_clk_i);
         check("buffer full", result_ready_o, 1'b0);
         result_valid_i <= 1'b0;
         host.xfer(1'b1, 8'h41, 8'h00, 24, rx);
         check("read word 0", rx, 24'h9A5C3E);
         check("read command", cmd_o, 8'h41);
         host.xfer(1'b0, 8'h43, 8'h00, 24, rx);
         check("read word 1", rx, 24'h1234F0);
         host.xfer(1'b1, 8'h45, 8'h00, 24, rx);
         check("empty read", rx, 24'h000000);
         check("buffer free", result_ready_o, 1'b1);
      end
   endtask
   task automatic s_hard;
      int oe0, busy0;
      reg [23:0] rx;
      begin
         hard_reset_n_i <= 1'b0;
         repeat (8) @(posedge core_clk_i);
         oe0 = oe_cnt;
         busy0 = busy_cnt;
         host.xfer(1'b1, 8'h41, 8'h00, 24, rx);
         check("reset oe", oe_cnt, oe0);
         check("reset busy", busy_cnt, busy0);
         hard_reset_n_i <= 1'b1;
         repeat (10) @(posedge core_clk_i);
      end
   endtask
   initial begin
      repeat (6) @(posedge core_clk_i);
      srst_i <= 1'b0;
      repeat (10) @(posedge core_clk_i);
      s_select;
      s_ready;
      s_read;
      s_hard;
      end_of_test;
   end
endmodule
